// File: hw/gms_config.sv
/*
 * Management-interrupt aggregation, voltage-id watchdogs, pin location
 * registers, two LED blinkers and voltage-id input snapshot.
 * Assumes a simple strobe register port and asynchronous peripheral irqs.
 */
`include "gms_regs.svh"
`default_nettype none
module gms_config
    import gms_pkg::*;
#(
    parameter int unsigned TICK_FAST  = `GMS_TICK_FAST,
    parameter int unsigned TICK_SLOW  = `GMS_TICK_SLOW,
    parameter int unsigned LED_BASE   = `GMS_LED_BASE_TICKS,
    parameter int unsigned SHORT_TICK = `GMS_SHORT_TICKS
) (
    // Clock, reset, enable
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    // Register port
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // Peripheral interrupts and inputs
    input  wire logic [6:0] i_periph_irq,
    input  wire logic [2:0] i_aux_irq,
    input  wire logic [1:0] i_button_detect,
    input  wire logic [7:0] i_voltage_id,
    // Outputs
    output logic            o_mgmt_interrupt_out,
    output logic      [5:0] o_mgmt_irq_loc,
    output logic      [5:0] o_thermal_loc,
    output logic      [5:0] o_beep_loc,
    output logic      [5:0] o_key_lock_loc,
    output logic      [5:0] o_led1_loc,
    output logic      [5:0] o_led2_loc,
    output logic            o_led1_out,
    output logic            o_led1_oe,
    output logic            o_led2_out,
    output logic            o_led2_oe,
    output logic      [1:0] o_wd_timeout
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    localparam int SW = 20;
    logic [SW-1:0] s1_q, s2_q, s3_q;
    logic [SW-1:0] sy;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (i_ce) begin
            s1_q <= {i_voltage_id, i_button_detect, i_aux_irq, i_periph_irq};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    // Stable value: updates once second and third stages agree
    logic [SW-1:0] stab_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stab_q <= '0;
        end else if (i_ce) begin
            for (int i = 0; i < SW; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    stab_q[i] <= s3_q[i];
                end
            end
        end
    end
    assign sy = stab_q;
    logic [6:0] periph;
    logic [2:0] aux;
    logic [1:0] btn;
    logic [7:0] voltage_id;
    assign periph = sy[6:0];
    assign aux    = sy[9:7];
    assign btn    = sy[11:10];
    assign voltage_id    = sy[19:12];

    // ----------------------------------------------------------------
    // Strobes
    // ----------------------------------------------------------------
    logic wr;
    assign wr = i_wr & i_ce;
    function automatic logic hit(input logic [7:0] idx);
        return wr && (i_addr == idx);
    endfunction

    // ----------------------------------------------------------------
    // Plain control registers
    // ----------------------------------------------------------------
    logic [7:0] en_a_q, en_b_q, irq_loc_q, therm_q, beep_q, klock_q;
    logic [7:0] led1_loc_q, led2_loc_q, led1_ctl_q, led2_ctl_q, wdc_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_a_q     <= `GMS_RST_BYTE;
            en_b_q     <= `GMS_RST_BYTE;
            irq_loc_q  <= `GMS_RST_BYTE;
            therm_q    <= `GMS_RST_BYTE;
            beep_q     <= `GMS_RST_BYTE;
            klock_q    <= `GMS_RST_BYTE;
            led1_loc_q <= `GMS_RST_BYTE;
            led2_loc_q <= `GMS_RST_BYTE;
            led1_ctl_q <= `GMS_RST_BYTE;
            led2_ctl_q <= `GMS_RST_BYTE;
            wdc_q      <= `GMS_RST_BYTE;
        end else begin
            if (hit(`GMS_IDX_EN_A)) en_a_q <= i_wdata & `GMS_EN_A_MASK;
            if (hit(`GMS_IDX_EN_B)) en_b_q <= i_wdata & `GMS_EN_B_MASK;
            if (hit(`GMS_IDX_IRQ_PIN)) irq_loc_q <= i_wdata & `GMS_LOC_MASK;
            if (hit(`GMS_IDX_THERM_PIN)) therm_q <= i_wdata & `GMS_LOC_MASK;
            if (hit(`GMS_IDX_BEEP_PIN)) beep_q <= i_wdata & `GMS_LOC_MASK;
            if (hit(`GMS_IDX_KLOCK_PIN)) klock_q <= i_wdata & `GMS_LOC_MASK;
            if (hit(`GMS_IDX_LED1_PIN)) led1_loc_q <= i_wdata & `GMS_LOC_MASK;
            if (hit(`GMS_IDX_LED2_PIN)) led2_loc_q <= i_wdata & `GMS_LOC_MASK;
            if (hit(`GMS_IDX_LED1_CTL)) led1_ctl_q <= i_wdata & `GMS_LED_CTL_MASK;
            if (hit(`GMS_IDX_LED2_CTL)) led2_ctl_q <= i_wdata & `GMS_LED_CTL_MASK;
            if (hit(`GMS_IDX_WD_CTL)) wdc_q <= {2'h0, i_wdata[5:2], 2'h0};
        end
    end
    // Location codes: group in [5:3], bit in [2:0], passed to pin mux
    assign o_mgmt_irq_loc = irq_loc_q[5:0];
    assign o_thermal_loc  = therm_q[5:0];
    assign o_beep_loc     = beep_q[5:0];
    assign o_key_lock_loc = klock_q[5:0];
    assign o_led1_loc     = led1_loc_q[5:0];
    assign o_led2_loc     = led2_loc_q[5:0];

    // ----------------------------------------------------------------
    // Voltage-id watchdogs
    // ----------------------------------------------------------------
    logic [7:0]  wd_set_q [2];
    logic [7:0]  wd_cnt_q [2];
    logic [22:0] wd_pre_q [2];
    logic [1:0]  wd_to_q;
    logic [1:0]  wd_en, wd_unit, wd_load, wd_expire;
    assign wd_en   = {wdc_q[`GMS_BIT_WD1_EN], wdc_q[`GMS_BIT_WD0_EN]};
    assign wd_unit = {wdc_q[`GMS_BIT_WD1_UNIT], wdc_q[`GMS_BIT_WD0_UNIT]};
    assign wd_load = {hit(`GMS_IDX_WD1), hit(`GMS_IDX_WD0)};
    for (genvar t = 0; t < 2; t++) begin : g_wd
        logic [22:0] lim;
        logic        tick;
        assign lim  = wd_unit[t] ? 23'(TICK_SLOW - 1) : 23'(TICK_FAST - 1);
        assign tick = (wd_pre_q[t] >= lim);
        assign wd_expire[t] = i_ce && wd_en[t] && tick && (wd_cnt_q[t] == 8'h01);
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                wd_set_q[t] <= 8'h00;
                wd_cnt_q[t] <= 8'h00;
                wd_pre_q[t] <= '0;
            end else if (wd_load[t]) begin
                wd_set_q[t] <= i_wdata;
                wd_cnt_q[t] <= i_wdata;
                wd_pre_q[t] <= '0;
            end else if (i_ce && wd_en[t] && wd_cnt_q[t] != 8'h00) begin
                if (tick) begin
                    wd_pre_q[t] <= '0;
                    wd_cnt_q[t] <= wd_cnt_q[t] - 8'h01;
                end else begin
                    wd_pre_q[t] <= wd_pre_q[t] + 23'h1;
                end
            end else if (i_ce) begin
                wd_pre_q[t] <= '0;
            end
        end
        // Set beats the write-one clear
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                wd_to_q[t] <= 1'b0;
            end else if (wd_expire[t]) begin
                wd_to_q[t] <= 1'b1;
            end else if (hit(`GMS_IDX_WD_CTL) && i_wdata[t]) begin
                wd_to_q[t] <= 1'b0;
            end
        end
    end
    assign o_wd_timeout = wd_to_q;

    // ----------------------------------------------------------------
    // Interrupt status and output
    // ----------------------------------------------------------------
    logic [6:0] st_a_q;
    logic [2:0] st_b_q;
    logic [1:0] btn_st_q, btn_prev_q;
    logic       clr_all;
    assign clr_all = hit(`GMS_IDX_EN_B) && i_wdata[`GMS_BIT_CLR_ALL];
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_a_q <= 7'h00;
            st_b_q <= 3'h0;
        end else if (i_ce) begin
            st_a_q <= periph;
            st_b_q <= aux;
        end
    end
    // Button detect latches; new detect wins over clear
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            btn_st_q   <= 2'h0;
            btn_prev_q <= 2'h0;
        end else if (i_ce) begin
            btn_prev_q <= btn;
            for (int i = 0; i < 2; i++) begin
                if (btn[i] && !btn_prev_q[i]) begin
                    btn_st_q[i] <= 1'b1;
                end else if (clr_all || (hit(`GMS_IDX_ST_B) && i_wdata[6+i])) begin
                    btn_st_q[i] <= 1'b0;
                end
            end
        end
    end
    logic [9:0] act, act_prev_q;
    logic       pulse_q;
    assign act = {st_b_q & en_b_q[2:0], st_a_q & en_a_q[6:0]};
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            act_prev_q <= 10'h000;
            pulse_q    <= 1'b0;
        end else if (i_ce) begin
            act_prev_q <= clr_all ? 10'h000 : act;
            pulse_q    <= |(act & ~act_prev_q);
        end
    end
    assign o_mgmt_interrupt_out = en_b_q[`GMS_BIT_LEVEL] ? (|act) : pulse_q;

    // ----------------------------------------------------------------
    // LED blinkers
    // ----------------------------------------------------------------
    logic [25:0] base_q;
    logic [5:0]  phase_q;
    logic        base_tick;
    assign base_tick = (base_q == 26'(LED_BASE - 1));
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            base_q  <= '0;
            phase_q <= 6'h00;
        end else if (i_ce) begin
            base_q <= base_tick ? 26'h0 : base_q + 26'h1;
            if (base_tick) phase_q <= phase_q + 6'h01;
        end
    end
    logic [7:0] led_ctl [2];
    logic [1:0] led_wave, led_short;
    logic [22:0] short_q [2];
    logic [1:0]  led_lvl, lvl_prev_q;
    assign led_ctl[0] = led1_ctl_q;
    assign led_ctl[1] = led2_ctl_q;
    for (genvar l = 0; l < 2; l++) begin : g_led
        always_comb begin
            case (gms_led_freq_t'(led_ctl[l][2:1]))
                GMS_LED_4HZ:   led_lvl[l] = phase_q[0];
                GMS_LED_1HZ:   led_lvl[l] = phase_q[2];
                GMS_LED_QTRHZ: led_lvl[l] = phase_q[4] & phase_q[3];
                GMS_LED_8THHZ: led_lvl[l] = phase_q[5];
                default:       led_lvl[l] = 1'b0;
            endcase
        end
        // Short low pulse on each falling step of the blink wave
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                short_q[l] <= '0;
            end else if (i_ce) begin
                if (lvl_prev_q[l] && !led_lvl[l]) begin
                    short_q[l] <= 23'(SHORT_TICK);
                end else if (short_q[l] != 23'h0) begin
                    short_q[l] <= short_q[l] - 23'h1;
                end
            end
        end
        assign led_short[l] = (short_q[l] == 23'h0);
        assign led_wave[l] = led_ctl[l][`GMS_BIT_LED_SHORT] ? led_short[l]
                                                           : led_lvl[l];
    end
    logic [1:0] led_out_q, led_oe_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lvl_prev_q <= 2'h0;
            led_out_q  <= 2'h3;
            led_oe_q   <= 2'h0;
        end else if (i_ce) begin
            lvl_prev_q <= led_lvl;
            led_out_q  <= led_wave;
            // Pin only driven while the low level is enabled
            led_oe_q   <= {led2_ctl_q[`GMS_BIT_LED_OE] & ~led_wave[1],
                           led1_ctl_q[`GMS_BIT_LED_OE] & ~led_wave[0]};
        end
    end
    assign o_led1_out = led_out_q[0];
    assign o_led2_out = led_out_q[1];
    assign o_led1_oe  = led_oe_q[0];
    assign o_led2_oe  = led_oe_q[1];

    // ----------------------------------------------------------------
    // Voltage-id snapshot
    // ----------------------------------------------------------------
    logic [7:0] vid_init_q;
    logic       vid_first_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vid_init_q  <= 8'h00;
            vid_first_q <= 1'b1;
        end else if (i_ce) begin
            vid_first_q <= 1'b0;
            if (vid_first_q || (hit(`GMS_IDX_VID_IN) && i_wdata[0])) begin
                vid_init_q <= voltage_id;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    logic [7:0] rd_d;
    always_comb begin
        case (i_addr)
            `GMS_IDX_WD0:       rd_d = wd_en[0] ? wd_cnt_q[0] : wd_set_q[0];
            `GMS_IDX_WD1:       rd_d = wd_en[1] ? wd_cnt_q[1] : wd_set_q[1];
            `GMS_IDX_EN_A:      rd_d = en_a_q;
            `GMS_IDX_EN_B:      rd_d = en_b_q;
            `GMS_IDX_ST_A:      rd_d = {1'b0, st_a_q};
            `GMS_IDX_ST_B:      rd_d = {btn_st_q, 3'h0, st_b_q};
            `GMS_IDX_IRQ_PIN:   rd_d = irq_loc_q;
            `GMS_IDX_THERM_PIN: rd_d = therm_q;
            `GMS_IDX_BEEP_PIN:  rd_d = beep_q;
            `GMS_IDX_KLOCK_PIN: rd_d = klock_q;
            `GMS_IDX_LED1_PIN:  rd_d = led1_loc_q;
            `GMS_IDX_LED1_CTL:  rd_d = led1_ctl_q;
            `GMS_IDX_LED2_PIN:  rd_d = led2_loc_q;
            `GMS_IDX_LED2_CTL:  rd_d = led2_ctl_q;
            `GMS_IDX_VID_IN:    rd_d = vid_init_q;
            `GMS_IDX_WD_CTL:    rd_d = wdc_q | {6'h00, wd_to_q};
            default:            rd_d = 8'h00;
        endcase
    end
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_ce && i_rd) begin
            o_rdata <= rd_d;
        end
    end

endmodule
`default_nettype wire

// File: hw/gms_pkg.sv
/*
 * Types shared by the register slice.
 * Assumes nothing beyond the constants header.
 */
`default_nettype none
package gms_pkg;
    typedef enum logic [1:0] {
        GMS_LED_4HZ   = 2'h0,
        GMS_LED_1HZ   = 2'h1,
        GMS_LED_QTRHZ = 2'h2,
        GMS_LED_8THHZ = 2'h3
    } gms_led_freq_t;
endpackage
`default_nettype wire

// File: hw/gms_regs.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * management-interrupt, pin-select, LED blinker and voltage-id register slice.
 * Assumes a 100 MHz core clock and an 8-bit indexed register port.
 */
//
// Contract
// - Writing a watchdog value reloads its countdown
// - Timer 0 reads value, or count when enabled
// - Timer 1 reads value, or count when enabled
// - First enable register gates seven peripheral sources
// - Second enable register gates watchdog, infrared, button
// - Control bit 7 clears all status, self-clearing
// - First status shows seven peripheral interrupt states
// - Second status shows watchdog, infrared, button states
// - Status bits 7-6 latch button detects, W1C
// - Pin select bits 5-0 place interrupt output
// - Thermal, beep, keylock each get six-bit location
// - Each blinker has its own location register
// - Blinker bits 2-1 pick 4,1,1/4,1/8 Hz
// - Blinker bit 3 gives short low pulses
// - Blinker bit 0 enables driving output low
// - Voltage-id input register is read-only inputs; code returns the vid_init_q snapshot instead
// - Writing bit 0 recaptures initial voltage-id
// - Watchdog unit 62.5 ms or about 1 ms
// - Expiry sets timeout flag, write 1 clears
// - Location code: port group high, bit low
`ifndef GMS_REGS_SVH
`define GMS_REGS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define GMS_IDX_WD0        8'hE5
`define GMS_IDX_WD1        8'hE6
`define GMS_IDX_EN_A       8'hF0
`define GMS_IDX_EN_B       8'hF1
`define GMS_IDX_ST_A       8'hF2
`define GMS_IDX_ST_B       8'hF3
`define GMS_IDX_IRQ_PIN    8'hF4
`define GMS_IDX_THERM_PIN  8'hF5
`define GMS_IDX_BEEP_PIN   8'hF6
`define GMS_IDX_KLOCK_PIN  8'hF7
`define GMS_IDX_LED1_PIN   8'hF8
`define GMS_IDX_LED1_CTL   8'hF9
`define GMS_IDX_LED2_PIN   8'hFA
`define GMS_IDX_LED2_CTL   8'hFB
`define GMS_IDX_VID_IN     8'hFC
`define GMS_IDX_WD_CTL     8'hFF

// ----------------------------------------------------------------
// Field positions and resets
// ----------------------------------------------------------------
`define GMS_RST_BYTE       8'h00
`define GMS_EN_A_MASK      8'h7F
`define GMS_EN_B_MASK      8'h47
`define GMS_SRC_B_MASK     8'h07
`define GMS_LOC_MASK       8'h3F
`define GMS_LED_CTL_MASK   8'h0F
`define GMS_WDC_MASK       8'h3F
`define GMS_BIT_CLR_ALL    7
`define GMS_BIT_LEVEL      6
`define GMS_BIT_WD0_EN     2
`define GMS_BIT_WD1_EN     3
`define GMS_BIT_WD0_UNIT   4
`define GMS_BIT_WD1_UNIT   5
`define GMS_BIT_WD0_TO     0
`define GMS_BIT_WD1_TO     1
`define GMS_BIT_LED_OE     0
`define GMS_BIT_LED_SHORT  3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define GMS_CLK_HZ         100000000
`define GMS_UNIT_FAST_US   1000
`define GMS_UNIT_SLOW_US   62500
`define GMS_TICK_FAST      (`GMS_CLK_HZ / 1000000 * `GMS_UNIT_FAST_US)
`define GMS_TICK_SLOW      (`GMS_CLK_HZ / 1000000 * `GMS_UNIT_SLOW_US)
`define GMS_LED_BASE_MS    125
`define GMS_LED_BASE_TICKS (`GMS_CLK_HZ / 1000 * `GMS_LED_BASE_MS)
`define GMS_SHORT_MS       50
`define GMS_SHORT_TICKS    (`GMS_CLK_HZ / 1000 * `GMS_SHORT_MS)

`endif

// File: tb/gms_config_checker.sv
/*
 * Port-level assertions for the register slice.
 * Assumes one core clock domain and a bind from the bench top file.
 */
`default_nettype none
module gms_config_checker (
    // Clock and reset
    input wire logic       i_core_clk,
    input wire logic       i_rst_n,
    // Register port
    input wire logic       i_ce,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    // Outputs
    input wire logic       o_mgmt_interrupt_out,
    input wire logic [5:0] o_mgmt_irq_loc,
    input wire logic [5:0] o_thermal_loc,
    input wire logic [1:0] o_wd_timeout
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    // ----------------------------------------------------------------
    // Shadow of written settings
    // ----------------------------------------------------------------
    logic       take_wr;
    logic       take_rd;
    logic       clr0;
    logic       wd0_en;
    logic       en_any;
    logic [5:0] wdata_loc;
    logic [7:0] wd0_q, wd1_q, en_a_q, en_b_q, wdc_q;
    assign take_wr   = i_wr && i_ce;
    assign take_rd   = i_rd && i_ce;
    assign clr0      = take_wr && i_addr == 8'hFF && i_wdata[0];
    assign wd0_en    = wdc_q[2];
    assign en_any    = |{en_a_q[6:0], en_b_q[2:0]};
    assign wdata_loc = i_wdata[5:0];
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wd0_q  <= 8'h00;
            wd1_q  <= 8'h00;
            en_a_q <= 8'h00;
            en_b_q <= 8'h00;
            wdc_q  <= 8'h00;
        end else if (take_wr) begin
            case (i_addr)
                8'hE5: wd0_q <= i_wdata;
                8'hE6: wd1_q <= i_wdata;
                8'hF0: en_a_q <= i_wdata;
                8'hF1: en_b_q <= i_wdata & 8'h47;
                8'hFF: wdc_q <= i_wdata & 8'h3C;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_IRQ_LOC_LOAD: assert property (take_wr && i_addr == 8'hF4
        |=> o_mgmt_irq_loc == $past(wdata_loc)) else $error("irq location not loaded");
    AST_LOC_HOLD: assert property (!take_wr |=> $stable(o_thermal_loc))
        else $error("thermal location moved without write");
    AST_EN_A_RSV: assert property (take_rd && i_addr == 8'hF0 |=> !o_rdata[7])
        else $error("enable a reserved bit set");
    AST_CLR_ALL_NONSTICKY: assert property (take_rd && i_addr == 8'hF1
        |=> !o_rdata[7] && o_rdata[5:3] == 3'h0) else $error("enable b clear or reserved bit set");
    AST_IRQ_QUIET: assert property (!en_any && !$past(en_any) && !$past(en_any, 2)
        |-> !o_mgmt_interrupt_out) else $error("interrupt with no source enabled");
    AST_TIMEOUT_CLEAR: assert property ($fell(o_wd_timeout[0]) |-> $past(clr0))
        else $error("timeout flag 0 dropped without clear");
    AST_TIMEOUT_SET: assert property ($rose(o_wd_timeout[0]) |-> $past(wd0_en))
        else $error("timeout flag 0 set while disabled");
    AST_WD0_READ: assert property (take_rd && i_addr == 8'hE5 && !wdc_q[2]
        |=> o_rdata == $past(wd0_q)) else $error("timer 0 setting not returned");
    AST_WD1_READ: assert property (take_rd && i_addr == 8'hE6 && !wdc_q[3]
        |=> o_rdata == $past(wd1_q)) else $error("timer 1 setting not returned");
endmodule
`default_nettype wire

// File: tb/gms_config_tb_top.sv
/*
 * Self-checking bench for the register slice.
 * Assumes shortened timing parameters and the checker bound below.
 */
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, (got), (exp)); end end
module gms_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TF = 4, TS = 16, LB = 8, ST = 2;
    logic       i_core_clk = 1'b0, i_rst_n, i_ce, i_wr, i_rd;
    logic [7:0] i_addr, i_wdata, i_voltage_id, o_rdata;
    logic [6:0] i_periph_irq;
    logic [2:0] i_aux_irq;
    logic [1:0] i_button_detect, o_wd_timeout;
    logic       o_mgmt_interrupt_out, o_led1_out, o_led1_oe, o_led2_out, o_led2_oe;
    logic [5:0] o_mgmt_irq_loc, o_thermal_loc, o_beep_loc, o_key_lock_loc, o_led1_loc;
    logic [5:0] o_led2_loc;
    int         n_errors = 0, n_checks = 0, cyc = 0, seed = 11892;

    gms_config #(.TICK_FAST(TF), .TICK_SLOW(TS), .LED_BASE(LB), .SHORT_TICK(ST)) dut (
        .i_core_clk, .i_rst_n, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_periph_irq, .i_aux_irq, .i_button_detect, .i_voltage_id,
        .o_mgmt_interrupt_out, .o_mgmt_irq_loc, .o_thermal_loc, .o_beep_loc,
        .o_key_lock_loc, .o_led1_loc, .o_led2_loc, .o_led1_out, .o_led1_oe,
        .o_led2_out, .o_led2_oe, .o_wd_timeout);

    always #5 i_core_clk = ~i_core_clk;

    // ----------------------------------------------------------------
    // Bus tasks, measurement and closing
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    // Cycles between two falling steps of a blinker, with its low and drive counts
    task automatic led_meas(input int l, output int per, output int low, output int oec);
        logic prv = 1'b0, cur;
        int   edges = 0;
        per = 0;
        low = 0;
        oec = 0;
        for (int k = 0; k < 3000 && edges < 2; k++) begin
            @(posedge i_core_clk);
            #1 cur = l ? o_led2_out : o_led1_out;
            if (edges == 1) begin
                per++;
                low += int'(!cur);
                oec += int'(l ? o_led2_oe : o_led1_oe);
            end
            if (prv && !cur) edges++;
            prv = cur;
        end
    endtask

    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            $display("[ERR] %0t run did not finish", $time);
            complete_run();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] d, v;
        logic [7:0] regs[15] = '{8'hE5, 8'hE6, 8'hE7, 8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4,
                                  8'hF5, 8'hF6, 8'hF7, 8'hF8, 8'hF9, 8'hFA, 8'hFB};
        logic [7:0] locs[6] = '{8'hF4, 8'hF5, 8'hF6, 8'hF7, 8'hF8, 8'hFA};
        logic [35:0] el;
        int         sh[4] = '{0, 2, 4, 5};
        int         per, low, oec, n;
        {i_rst_n, i_wr, i_rd, i_addr, i_wdata, i_voltage_id} <= '0;
        {i_periph_irq, i_aux_irq, i_button_detect} <= '0;
        i_ce <= 1'b1;
        repeat (16) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        foreach (regs[k]) begin
            rd(regs[k], d);
            `CHK(d, 8'h00)
        end
        foreach (locs[k]) begin
            v = 8'($random(seed));
            el = {el[29:0], v[5:0]};
            wr(locs[k], v);
            rd(locs[k], d);
            `CHK(d, v & 8'h3F)
        end
        i_ce <= 1'b0;
        wr(8'hF5, 8'h2A);
        i_ce <= 1'b1;
        `CHK({o_mgmt_irq_loc, o_thermal_loc, o_beep_loc}, el[35:18])
        `CHK({o_key_lock_loc, o_led1_loc, o_led2_loc}, el[17:0])
        wr(8'hF4, 8'hC8);
        #1 `CHK(o_mgmt_irq_loc, 6'h08)
        v = 8'($random(seed));
        wr(8'hF0, v);
        rd(8'hF0, d);
        `CHK(d, v & 8'h7F)
        wr(8'hF1, v | 8'h80);
        rd(8'hF1, d);
        `CHK(d, v & 8'h47)
        v = 8'($random(seed)) | 8'h01;
        i_periph_irq <= v[6:0];
        i_aux_irq <= 3'h5;
        repeat (6) @(posedge i_core_clk);
        rd(8'hF2, d);
        `CHK(d, {1'b0, v[6:0]})
        rd(8'hF3, d);
        `CHK(d[2:0], 3'h5)
        for (int b = 0; b < 10; b++) begin
            wr(8'hF0, b < 7 ? 8'h01 << b : 8'h00);
            wr(8'hF1, b < 7 ? 8'h40 : 8'h40 | (8'h01 << (b - 7)));
            #1 `CHK(o_mgmt_interrupt_out, b < 7 ? v[b] : i_aux_irq[b - 7])
        end
        {i_periph_irq, i_aux_irq} <= '0;
        wr(8'hF1, 8'h04);
        wr(8'hF0, 8'h00);
        repeat (6) @(posedge i_core_clk);
        i_aux_irq <= 3'h4;
        for (int r = 0; r < 2; r++) begin
            if (r == 1) wr(8'hF1, 8'h84);
            n = 0;
            repeat (12) begin
                @(posedge i_core_clk);
                #1 n += int'(o_mgmt_interrupt_out);
            end
            `CHK(n, 1)
        end
        i_aux_irq <= 3'h0;
        i_button_detect <= 2'h3;
        repeat (6) @(posedge i_core_clk);
        i_button_detect <= 2'h0;
        rd(8'hF3, d);
        `CHK(d[7:6], 2'h3)
        wr(8'hF3, 8'h40);
        rd(8'hF3, d);
        `CHK(d[7:6], 2'h2)
        wr(8'hF1, 8'h80);
        rd(8'hF3, d);
        `CHK(d[7:6], 2'h0)
        wr(8'hE5, 8'h03);
        rd(8'hE5, d);
        `CHK(d, 8'h03)
        wr(8'hFF, 8'h04);
        repeat (25) @(posedge i_core_clk);
        #1 `CHK(o_wd_timeout, 2'b01)
        rd(8'hE5, d);
        `CHK(d, 8'h00)
        wr(8'hFF, 8'h05);
        #1 `CHK(o_wd_timeout, 2'b00)
        wr(8'hE5, 8'h0A);
        rd(8'hE5, d);
        `CHK(d, 8'h0A)
        wr(8'hE6, 8'h02);
        wr(8'hFF, 8'h28);
        repeat (20) @(posedge i_core_clk);
        #1 `CHK(o_wd_timeout, 2'b00)
        repeat (25) @(posedge i_core_clk);
        #1 `CHK(o_wd_timeout, 2'b10)
        rd(8'hE5, d);
        `CHK(d, 8'h0A)
        for (int f = 0; f < 4; f++) begin
            for (int l = 0; l < 2; l++) begin
                wr(l ? 8'hFB : 8'hF9, {5'h00, 2'(f), 1'b1});
                led_meas(l, per, low, oec);
                led_meas(l, per, low, oec);
                `CHK(per, 16 << sh[f])
                `CHK(oec, low)
            end
        end
        for (int m = 0; m < 3; m++) begin
            wr(8'hF9, m == 0 ? 8'h01 : (m == 1 ? 8'h09 : 8'h08));
            led_meas(0, per, low, oec);
            led_meas(0, per, low, oec);
            `CHK(m == 2 ? oec : low, m == 0 ? LB : (m == 1 ? ST : 0))
        end
        v = 8'($random(seed));
        i_voltage_id <= v;
        repeat (6) @(posedge i_core_clk);
        wr(8'hFC, 8'h01);
        rd(8'hFC, d);
        `CHK(d, v)
        i_voltage_id <= ~v;
        repeat (6) @(posedge i_core_clk);
        wr(8'hFC, 8'hFE);
        rd(8'hFC, d);
        `CHK(d, v)
        complete_run();
    end
endmodule

bind gms_config gms_config_checker u_chk (.i_core_clk, .i_rst_n, .i_ce, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .o_mgmt_interrupt_out, .o_mgmt_irq_loc, .o_thermal_loc,
    .o_wd_timeout);
`default_nettype wire
